// [core/onoff_controller_fsm.sv]
// top-level on/off state machine with register port and interrupt
// Function
// - cold-reset code or watchdog reset starts reset
// - action states exit only when actions complete
// - off code, watchdog off, lockouts, manual reset
// - auto wake code starts auto wake actions
// - leave por only when supply above threshold
// - force enable or wake flag starts bias
// - bias timer expired and no lockout advances
// - power-up needs not done, not forced off, wake
// - sequencer up done enters resource-on
// - codes, watchdog, manual reset start power-down
// - converter fault with enable starts power-down
// - power-down done goes to requested action
// - last resource off returns to shutdown
// - enable debounce sets wake flag
// - cold-reset code sets wake flag
// - reset output released after up, asserted before down
module onoff_controller_fsm
    import onoff_pkg::*;
#(
    parameter int BIAS_CYCLES = BIAS_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // analog monitors (asynchronous)
    input wire logic sys_above_por,
    input wire lockout_s lockout_in,
    input wire logic converter_fault,
    // on-chip events and levels
    input wire logic enable_debounced,
    input wire logic watchdog_expired,
    input wire logic manual_reset,
    input wire logic force_enabled,
    input wire logic force_off,
    input wire logic seq_up_done,
    input wire logic seq_down_done,
    input wire logic last_resource_off,
    input wire action_done_s action_done,
    // controls out
    output action_s actions,
    output logic [3:0] state_out,
    output logic irq,
    // open-drain reset output
    output logic reset_output_n_o,
    output logic reset_output_n_oe
);
    // ==========================================================
    // synchronisers for analog levels
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign sync_in = {sys_above_por, lockout_in, converter_fault};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                sync1_r[i] <= 1'b0;
                sync2_r[i] <= 1'b0;
            end else begin
                sync1_r[i] <= sync_in[i];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end

    logic por_ok;
    logic fault_s;
    logic lockout_any;
    assign por_ok = sync2_r[4];
    assign lockout_any = |sync2_r[3:1];
    assign fault_s = sync2_r[0];

    // ==========================================================
    // register state
    onoff_state_e state_r, state_nxt;
    logic wdt_action_r, wdt_action_nxt;
    logic fault_shdn_r, fault_shdn_nxt;
    logic [CAUSE_W-1:0] cause_r, cause_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
    logic up_done_r, up_done_nxt;
    logic wake_r, wake_nxt;
    sw_code_e pend_r, pend_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    action_s act_nxt;
    logic irq_nxt;
    logic rst_assert_nxt;
    logic rst_assert_r;

    logic bias_expired;
    logic code_wr;
    sw_code_e code;
    logic watchdog_reset_cause_ev;
    logic watchdog_off_cause_ev;
    logic off_ev;

    bias_timer #(
        .COUNT(BIAS_CYCLES)
    ) u_bias (
        .clk(clk),
        .rstn(rstn),
        .run(state_r == ST_BIAS),
        .expired(bias_expired)
    );

    // a zero code is no request
    assign code = sw_code_e'(reg_wdata[CTRL_CODE_LSB +: 2]);
    assign code_wr = reg_wr && (reg_addr == ADDR_CTRL) && (code != CODE_NONE);
    assign watchdog_reset_cause_ev = watchdog_expired && wdt_action_r;
    assign watchdog_off_cause_ev = watchdog_expired && !wdt_action_r;
    // manual reset acts at the moment it is recorded, so a stale flag cannot loop
    assign off_ev = watchdog_off_cause_ev || manual_reset || lockout_any
        || (code_wr && code == CODE_POWER_OFF);

    // ==========================================================
    // state machine
    always_comb begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        up_done_nxt = up_done_r;
        unique case (state_r)
            ST_POR: begin
                if (por_ok) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            ST_SHUTDOWN, ST_BIAS, ST_SEQ_UP: begin
                if ((code_wr && code == CODE_COLD_RESET) || watchdog_reset_cause_ev) begin
                    state_nxt = ST_RESET_ACT;
                end else if (off_ev) begin
                    state_nxt = ST_OFF_ACT;
                end else if (code_wr && code == CODE_AUTO_WAKE) begin
                    state_nxt = ST_WAKE_ACT;
                end else if (state_r == ST_SHUTDOWN) begin
                    if (force_enabled || wake_r) begin
                        state_nxt = ST_BIAS;
                    end
                end else if (state_r == ST_BIAS) begin
                    if (bias_expired) begin
                        state_nxt = (!up_done_r && !force_off && wake_r) ? ST_SEQ_UP : ST_RES_ON;
                    end
                end else if (seq_up_done) begin
                    state_nxt = ST_RES_ON;
                    up_done_nxt = 1'b1;
                end
            end
            ST_RES_ON: begin
                if (code_wr) begin
                    state_nxt = ST_SEQ_DOWN;
                    pend_nxt = code;
                end else if (watchdog_reset_cause_ev) begin
                    state_nxt = ST_SEQ_DOWN;
                    pend_nxt = CODE_COLD_RESET;
                end else if (off_ev || (fault_shdn_r && fault_s)) begin
                    state_nxt = ST_SEQ_DOWN;
                    pend_nxt = CODE_POWER_OFF;
                end else if (last_resource_off) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            ST_SEQ_DOWN: begin
                if (seq_down_done) begin
                    up_done_nxt = 1'b0;
                    unique case (pend_r)
                        CODE_COLD_RESET: state_nxt = ST_RESET_ACT;
                        CODE_AUTO_WAKE: state_nxt = ST_WAKE_ACT;
                        default: state_nxt = ST_OFF_ACT;
                    endcase
                end
            end
            ST_RESET_ACT: begin
                if (action_done.reset_done) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            ST_OFF_ACT: begin
                if (action_done.off_done) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            ST_WAKE_ACT: begin
                if (action_done.wake_done) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            default: state_nxt = ST_POR;
        endcase
    end

    // ==========================================================
    // wake flag, cause flags, control fields
    always_comb begin
        wake_nxt = wake_r;
        if (state_nxt == ST_SEQ_UP) begin
            wake_nxt = 1'b0;
        end
        // set wins over the consuming clear
        if (enable_debounced) begin
            wake_nxt = 1'b1;
        end
        if (code_wr && (code == CODE_COLD_RESET || code == CODE_AUTO_WAKE)) begin
            wake_nxt = 1'b1;
        end
        wdt_action_nxt = wdt_action_r;
        fault_shdn_nxt = fault_shdn_r;
        irq_en_nxt = irq_en_r;
        cause_nxt = cause_r;
        irq_stat_nxt = irq_stat_r;
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            wdt_action_nxt = reg_wdata[CTRL_WDT_ACTION];
            fault_shdn_nxt = reg_wdata[CTRL_FAULT_SHDN];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
            irq_en_nxt = reg_wdata[IRQ_W-1:0];
        end
        if (reg_wr && reg_addr == ADDR_CAUSE) begin
            cause_nxt = cause_r & ~reg_wdata[CAUSE_W-1:0];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_CLR) begin
            irq_stat_nxt = irq_stat_r & ~reg_wdata[IRQ_W-1:0];
        end
        cause_nxt[CAUSE_WATCHDOG_RESET_CAUSE] = cause_nxt[CAUSE_WATCHDOG_RESET_CAUSE] | watchdog_reset_cause_ev;
        cause_nxt[CAUSE_WATCHDOG_OFF_CAUSE] = cause_nxt[CAUSE_WATCHDOG_OFF_CAUSE] | watchdog_off_cause_ev;
        cause_nxt[CAUSE_MANUAL_RESET_CAUSE] = cause_nxt[CAUSE_MANUAL_RESET_CAUSE] | manual_reset;
        irq_stat_nxt[IRQ_RES_ON] = irq_stat_nxt[IRQ_RES_ON] | (state_nxt == ST_RES_ON && state_r != ST_RES_ON);
        irq_stat_nxt[IRQ_SHDN] = irq_stat_nxt[IRQ_SHDN] | (state_nxt == ST_SHUTDOWN && state_r != ST_SHUTDOWN);
        irq_stat_nxt[IRQ_WDT] = irq_stat_nxt[IRQ_WDT] | watchdog_expired;
        irq_stat_nxt[IRQ_MANUAL_RESET_CAUSE] = irq_stat_nxt[IRQ_MANUAL_RESET_CAUSE] | manual_reset;
        irq_nxt = |(irq_stat_nxt & irq_en_nxt);
    end

    // ==========================================================
    // read mux and outputs
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    rdata_nxt[CTRL_WDT_ACTION] = wdt_action_r;
                    rdata_nxt[CTRL_FAULT_SHDN] = fault_shdn_r;
                end
                ADDR_CAUSE: rdata_nxt[CAUSE_W-1:0] = cause_r;
                ADDR_STATE: begin
                    rdata_nxt[3:0] = state_r;
                    rdata_nxt[ST_UP_DONE] = up_done_r;
                    rdata_nxt[ST_WAKE] = wake_r;
                end
                ADDR_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
                ADDR_IRQ_EN: rdata_nxt[IRQ_W-1:0] = irq_en_r;
                default: rdata_nxt = '0;
            endcase
        end
        act_nxt.bias_en = (state_nxt != ST_POR) && (state_nxt != ST_SHUTDOWN);
        act_nxt.seq_up_req = (state_nxt == ST_SEQ_UP);
        // power-down request trails reset assertion by one cycle
        act_nxt.seq_down_req = (state_r == ST_SEQ_DOWN) && (state_nxt == ST_SEQ_DOWN);
        act_nxt.reset_act = (state_nxt == ST_RESET_ACT);
        act_nxt.off_act = (state_nxt == ST_OFF_ACT);
        act_nxt.wake_act = (state_nxt == ST_WAKE_ACT);
        rst_assert_nxt = (state_nxt != ST_RES_ON);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_POR;
            pend_r <= CODE_NONE;
            up_done_r <= 1'b0;
            wake_r <= 1'b0;
            wdt_action_r <= RST_WDT_ACTION;
            fault_shdn_r <= RST_FAULT_SHDN;
            cause_r <= '0;
            irq_stat_r <= '0;
            irq_en_r <= RST_IRQ_EN;
            irq <= 1'b0;
            reg_rdata <= '0;
            actions <= '0;
            rst_assert_r <= 1'b1;
            state_out <= ST_POR;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            up_done_r <= up_done_nxt;
            wake_r <= wake_nxt;
            wdt_action_r <= wdt_action_nxt;
            fault_shdn_r <= fault_shdn_nxt;
            cause_r <= cause_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq <= irq_nxt;
            reg_rdata <= rdata_nxt;
            actions <= act_nxt;
            rst_assert_r <= rst_assert_nxt;
            state_out <= state_nxt;
        end
    end

    assign reset_output_n_o = 1'b0;
    assign reset_output_n_oe = rst_assert_r;

    // ==========================================================
    // assertions
    localparam int DN_LO = 1;
    sequence s_enter_res_on;
        state_r != ST_RES_ON ##1 state_r == ST_RES_ON;
    endsequence
    sequence s_leave_res_on;
        state_r == ST_RES_ON ##1 state_r == ST_SEQ_DOWN;
    endsequence

    property p_por_exit;
        @(posedge clk) disable iff (!rstn) state_r == ST_POR && state_nxt != ST_POR |-> por_ok;
    endproperty
    a_por_exit: assert property (p_por_exit) else $error("left por without supply");

    property p_bias_entry;
        @(posedge clk) disable iff (!rstn)
            state_r == ST_SHUTDOWN ##1 state_r == ST_BIAS |-> $past(force_enabled || wake_r);
    endproperty
    a_bias_entry: assert property (p_bias_entry) else $error("bias without wake cause");

    property p_bias_exit;
        @(posedge clk) disable iff (!rstn)
            state_r == ST_BIAS ##1 (state_r == ST_SEQ_UP || state_r == ST_RES_ON) |-> $past(bias_expired && !lockout_any);
    endproperty
    a_bias_exit: assert property (p_bias_exit) else $error("bias left early");

    property p_seq_up;
        @(posedge clk) disable iff (!rstn)
            state_r == ST_BIAS ##1 state_r == ST_SEQ_UP |-> $past(!up_done_r && !force_off && wake_r);
    endproperty
    a_seq_up: assert property (p_seq_up) else $error("power-up gating wrong");

    property p_rst_release;
        @(posedge clk) disable iff (!rstn) s_enter_res_on |-> !reset_output_n_oe;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset not released");

    property p_rst_before_down;
        @(posedge clk) disable iff (!rstn)
            s_leave_res_on |-> reset_output_n_oe && !actions.seq_down_req ##DN_LO actions.seq_down_req || state_r != ST_SEQ_DOWN;
    endproperty
    a_rst_before_down: assert property (p_rst_before_down) else $error("power-down before reset");

    property p_action_exit;
        @(posedge clk) disable iff (!rstn)
            state_r == ST_OFF_ACT ##1 state_r != ST_OFF_ACT |-> $past(action_done.off_done);
    endproperty
    a_action_exit: assert property (p_action_exit) else $error("off actions not done");

    property p_down_dest;
        @(posedge clk) disable iff (!rstn)
            state_r == ST_SEQ_DOWN && seq_down_done && pend_r == CODE_COLD_RESET |=> state_r == ST_RESET_ACT;
    endproperty
    a_down_dest: assert property (p_down_dest) else $error("wrong action after down");

    property p_wake_flag;
        @(posedge clk) disable iff (!rstn) enable_debounced |=> wake_r;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set");

    property p_wdt_cause;
        @(posedge clk) disable iff (!rstn) watchdog_expired && wdt_action_r |=> cause_r[CAUSE_WATCHDOG_RESET_CAUSE];
    endproperty
    a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog cause lost");
endmodule

// [inc/onoff_pkg.sv]
// package: on/off controller constants, states and carriers
package onoff_pkg;

    // ==========================================================
    // register map (word indices on the plain register port)
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CAUSE = 3'h1;
    localparam logic [2:0] ADDR_STATE = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
    localparam logic [2:0] ADDR_IRQ_CLR = 3'h4;
    localparam logic [2:0] ADDR_IRQ_EN = 3'h5;
    localparam int DATA_W = 8;

    // ==========================================================
    // field positions
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_WDT_ACTION = 2;
    localparam int CTRL_FAULT_SHDN = 3;
    localparam int CAUSE_WATCHDOG_RESET_CAUSE = 0;
    localparam int CAUSE_WATCHDOG_OFF_CAUSE = 1;
    localparam int CAUSE_MANUAL_RESET_CAUSE = 2;
    localparam int CAUSE_W = 3;
    localparam int ST_UP_DONE = 4;
    localparam int ST_WAKE = 5;
    localparam int IRQ_W = 4;
    localparam int IRQ_RES_ON = 0;
    localparam int IRQ_SHDN = 1;
    localparam int IRQ_WDT = 2;
    localparam int IRQ_MANUAL_RESET_CAUSE = 3;

    // ==========================================================
    // reset values
    localparam logic RST_WDT_ACTION = 1'b1;
    localparam logic RST_FAULT_SHDN = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ_EN = 4'h0;

    // ==========================================================
    // software control codes
    typedef enum logic [1:0] {
        CODE_NONE = 2'h0,
        CODE_COLD_RESET = 2'h1,
        CODE_POWER_OFF = 2'h2,
        CODE_AUTO_WAKE = 2'h3
    } sw_code_e;

    // ==========================================================
    // timing: bias enable delay in ns at a 20 ns clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIAS_DELAY_NS = 10000;
    localparam int BIAS_DELAY_CYC = (BIAS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // controller states, gray along power-up path
    typedef enum logic [3:0] {
        ST_POR = 4'h0,
        ST_SHUTDOWN = 4'h1,
        ST_BIAS = 4'h3,
        ST_SEQ_UP = 4'h2,
        ST_RES_ON = 4'h6,
        ST_SEQ_DOWN = 4'h7,
        ST_RESET_ACT = 4'h5,
        ST_OFF_ACT = 4'h4,
        ST_WAKE_ACT = 4'hc
    } onoff_state_e;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic otlo;
        logic uvlo;
        logic ovlo;
    } lockout_s;

    typedef struct packed {
        logic bias_en;
        logic seq_up_req;
        logic seq_down_req;
        logic reset_act;
        logic off_act;
        logic wake_act;
    } action_s;

    typedef struct packed {
        logic reset_done;
        logic off_done;
        logic wake_done;
    } action_done_s;

endpackage

// [core/bias_timer.sv]
// bias enable delay timer: counts while enabled, flags expiry
module bias_timer
    import onoff_pkg::*;
#(
    parameter int COUNT = BIAS_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic run,
    output logic expired
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT);

    if (COUNT < 1) begin : g_count_check
        $error("bias_timer: COUNT must be at least 1");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!run) begin
            cnt_nxt = '0;
        end else if (cnt_r != LAST) begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = run && (cnt_r == LAST);
endmodule

// [tb/onoff_controller_fsm_test.sv]
// self-checking bench for the on/off controller state machine
module onoff_controller_fsm_test;
    import onoff_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    localparam int BC = 8;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic sys_above_por = 1'b0;
    lockout_s lockout_in = '0;
    logic converter_fault = 1'b0;
    logic enable_debounced = 1'b0;
    logic watchdog_expired = 1'b0;
    logic manual_reset = 1'b0;
    logic force_enabled = 1'b0;
    logic force_off = 1'b0;
    logic seq_up_done = 1'b0;
    logic seq_down_done = 1'b0;
    logic last_resource_off = 1'b0;
    action_done_s action_done = '0;
    action_s actions;
    logic [3:0] state_out;
    logic irq;
    logic reset_output_n_o;
    logic reset_output_n_oe;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 36774;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    string nm_q[$];
    logic [7:0] exp_v;
    string nm_v;

`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", n, e, g); end end

    always #10 clk = ~clk;

    onoff_controller_fsm #(.BIAS_CYCLES(BC)) DUT (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_above_por(sys_above_por), .lockout_in(lockout_in),
        .converter_fault(converter_fault), .enable_debounced(enable_debounced),
        .watchdog_expired(watchdog_expired), .manual_reset(manual_reset), .force_enabled(force_enabled),
        .force_off(force_off), .seq_up_done(seq_up_done), .seq_down_done(seq_down_done),
        .last_resource_off(last_resource_off), .action_done(action_done), .actions(actions),
        .state_out(state_out), .irq(irq), .reset_output_n_o(reset_output_n_o),
        .reset_output_n_oe(reset_output_n_oe)
    );

    // ==========================================================
    // read data monitor: data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0) begin
            // pop once: the macro reads its expected value twice
            exp_v = exp_q.pop_front();
            nm_v = nm_q.pop_front();
            `CHK(nm_v, exp_v, reg_rdata)
        end
    end

    // ==========================================================
    // tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    // bounded wait until state equals (eq=1) or leaves (eq=0) s
    task automatic wait_st(input logic [3:0] s, input bit eq);
        int n;
        n = 0;
        while (((state_out === s) != eq) && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            num_errors++;
            $display("unexpected state_out: expected %h seen %h", s, state_out);
            end_sim();
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        if (k == 0) enable_debounced <= 1'b1;
        if (k == 1) watchdog_expired <= 1'b1;
        if (k == 2) manual_reset <= 1'b1;
        @(posedge clk);
        enable_debounced <= 1'b0;
        watchdog_expired <= 1'b0;
        manual_reset <= 1'b0;
    endtask

    task automatic power_up(input bit wake_exp);
        int cnt;
        bit p;
        p = 1'b0;
        cnt = 0;
        repeat (3) @(posedge clk);
        if (wake_exp) `CHK("wake_flag", 1'b1, state_out !== ST_SHUTDOWN)
        if (state_out === ST_SHUTDOWN) begin
            pulse(0);
            p = 1'b1;
        end
        wait_st(ST_BIAS, 1'b1);
        `CHK("bias_en", 1'b1, actions.bias_en)
        while (state_out === ST_BIAS && cnt < 1000) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= 1000) begin
            num_errors++;
            end_sim();
        end
        // bias stays the count plus its entry cycle
        if (p) `CHK("bias_len", BC + 1, cnt)
        `CHK("state_out", ST_SEQ_UP, state_out)
        @(posedge clk);
        `CHK("seq_up_req", 1'b1, actions.seq_up_req)
        seq_up_done <= 1'b1;
        wait_st(ST_RES_ON, 1'b1);
        `CHK("reset_oe", 1'b0, reset_output_n_oe)
        seq_up_done <= 1'b0;
    endtask

    // ==========================================================
    // shutdown causes: control value, trigger kind, action state, cause bits
    logic [7:0] ctl_v [7] = '{8'h05, 8'h06, 8'h07, 8'h04, 8'h00, 8'h04, 8'h08};
    int kind [7] = '{0, 0, 0, 1, 1, 2, 3};
    logic [3:0] exp_s [7] = '{ST_RESET_ACT, ST_OFF_ACT, ST_WAKE_ACT, ST_RESET_ACT, ST_OFF_ACT, ST_OFF_ACT, ST_OFF_ACT};
    logic [7:0] exp_c [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h04, 8'h00};

    initial begin
        logic [3:0] r;
        logic [3:0] st;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("state_out", ST_POR, state_out)
        `CHK("reset_oe", 1'b1, reset_output_n_oe)
        `CHK("reset_o", 1'b0, reset_output_n_o)
        sys_above_por <= 1'b1;
        wait_st(ST_SHUTDOWN, 1'b1);
        power_up(1'b0);
        rd(ADDR_STATE, 8'h16, "state_reg");
        wr(ADDR_CTRL, 8'h04);
        repeat (3) @(posedge clk);
        `CHK("state_out", ST_RES_ON, state_out)
        rd(ADDR_CTRL, 8'h04, "ctrl_reg");
        rd(ADDR_IRQ_STAT, 8'h03, "irq_stat");
        r = 4'($random(seed));
        wr(ADDR_IRQ_EN, {4'h0, r});
        repeat (2) @(posedge clk);
        `CHK("irq", |(r & 4'h3), irq)
        wr(ADDR_IRQ_EN, 8'h01);
        rd(ADDR_IRQ_EN, 8'h01, "irq_en");
        wr(ADDR_IRQ_CLR, 8'h0f);
        rd(ADDR_IRQ_STAT, 8'h00, "irq_stat");
        `CHK("irq", 1'b0, irq)
        r = 4'($random(seed));
        wr({2'b11, r[0]}, 8'hff);
        rd({2'b11, r[0]}, 8'h00, "unmapped");
        for (int i = 0; i < 7; i++) begin
            if (i > 0) power_up(i == 1 || i == 3);
            if (kind[i] == 3) begin
                wr(ADDR_CTRL, 8'h00);
                converter_fault <= 1'b1;
                repeat (6) @(posedge clk);
                `CHK("state_out", ST_RES_ON, state_out)
            end
            wr(ADDR_CTRL, ctl_v[i]);
            if (kind[i] == 1 || kind[i] == 2) pulse(kind[i]);
            wait_st(ST_SEQ_DOWN, 1'b1);
            `CHK("reset_oe", 1'b1, reset_output_n_oe)
            `CHK("seq_down_req", 1'b0, actions.seq_down_req)
            converter_fault <= 1'b0;
            @(posedge clk);
            `CHK("seq_down_req", 1'b1, actions.seq_down_req)
            seq_down_done <= 1'b1;
            wait_st(ST_SEQ_DOWN, 1'b0);
            seq_down_done <= 1'b0;
            st = state_out;
            if (exp_s[i] !== 4'hf) `CHK("state_out", exp_s[i], st)
            repeat (4) @(posedge clk);
            `CHK("state_out", st, state_out)
            `CHK("act_lvls", ({exp_s[i] == ST_RESET_ACT, exp_s[i] == ST_OFF_ACT, exp_s[i] == ST_WAKE_ACT}), actions[2:0])
            action_done <= 3'b111;
            wait_st(ST_SHUTDOWN, 1'b1);
            action_done <= 3'b000;
            rd(ADDR_CAUSE, exp_c[i], "cause_reg");
            wr(ADDR_CAUSE, 8'h07);
        end
        force_off <= 1'b1;
        // wake flag is clear here, so only the force enable can start bias
        force_enabled <= 1'b1;
        wait_st(ST_BIAS, 1'b1);
        wait_st(ST_BIAS, 1'b0);
        `CHK("state_out", ST_RES_ON, state_out)
        last_resource_off <= 1'b1;
        wait_st(ST_SHUTDOWN, 1'b1);
        `CHK("state_out", ST_SHUTDOWN, state_out)
        last_resource_off <= 1'b0;
        force_off <= 1'b0;
        force_enabled <= 1'b0;
        pulse(0);
        wait_st(ST_BIAS, 1'b1);
        lockout_in <= 3'b001 << ({$random(seed)} % 3);
        wait_st(ST_BIAS, 1'b0);
        `CHK("state_out", ST_OFF_ACT, state_out)
        lockout_in <= '0;
        action_done <= 3'b111;
        wait_st(ST_SHUTDOWN, 1'b1);
        repeat (3) @(posedge clk);
        end_sim();
    end

endmodule
